// ===== vtsd_top.sv
// vtsd_top: line-state detector plus vt circuit supervisor decision logic
// assumes magnitudes and thresholds arrive in percent, same clock, refreshed every ms
//
// Behaviour
// RQ1: dead line only when all phase voltages and currents are below thresholds
// RQ2: live line only when all three phase voltages exceed voltage threshold
// RQ3: per-phase voltage pickup flag when that voltage is above threshold
// RQ4: per-phase current pickup flag when that current is above threshold
// RQ5: residual mode: residual voltage high and residual current low
// RQ6: negative-sequence mode: negative voltage high and negative current low
// RQ7: special mode: residual voltage high, residual and negative currents low
// RQ8: arm supervision after live line held continuously 200 ms
// RQ9: disarm on dead line, except a fault already latched
// RQ10: when armed, fault flag after condition held 4 ms
// RQ11: supervision works only when detector enabled and not inhibited
// RQ12: condition gone on live line, fault drops after 200 ms
// RQ13: dead line after fault held 100 ms latches the fault
// RQ14: dead line after fault held under 100 ms clears the fault
// RQ15: no event records are produced here
// RQ16: dead and live line statuses are offered as monitoring outputs
// RQ17: on/off enable, off after reset, off forces outputs low
// RQ18: inhibit input forces all detector outputs inactive
// RQ19: voltage threshold 10..100 default 60, current 2..100 default 10
// RQ20: durations counted on ms tick, counters restart when condition drops
// RQ21: preprocessing supplies magnitudes in common scale every ms
// RQ22: mode 0 residual, 1 negative-sequence, 2 special combined
`timescale 1ns/1ns
`default_nettype none
module vtsd_top #(
  parameter int unsigned MAG_W     = vtsd_pkg::MAG_W,
  parameter int unsigned TICK_DIV  = vtsd_pkg::TICK_CYCLES,
  parameter int unsigned ARM_MS    = vtsd_pkg::ARM_MS,
  parameter int unsigned FAIL_MS   = vtsd_pkg::FAIL_MS,
  parameter int unsigned RESET_MS  = vtsd_pkg::RESET_MS,
  parameter int unsigned LATCH_MS  = vtsd_pkg::LATCH_MS
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             detector_enable,
  input  wire logic             line_state_inhibit,
  input  wire logic [7:0]       voltage_threshold_pct,
  input  wire logic [7:0]       current_threshold_pct,
  input  wire logic [MAG_W-1:0] phase_voltage_mag [3],
  input  wire logic [MAG_W-1:0] phase_current_mag [3],
  input  wire logic [1:0]       supervision_mode,
  input  wire logic [MAG_W-1:0] residual_voltage_mag,
  input  wire logic [MAG_W-1:0] residual_current_mag,
  input  wire logic [MAG_W-1:0] negseq_voltage_mag,
  input  wire logic [MAG_W-1:0] negseq_current_mag,
  input  wire logic [MAG_W-1:0] residual_voltage_thr,
  input  wire logic [MAG_W-1:0] residual_current_thr,
  input  wire logic [MAG_W-1:0] negseq_voltage_thr,
  input  wire logic [MAG_W-1:0] negseq_current_thr,
  output logic                  phase1_voltage_pickup,
  output logic                  phase2_voltage_pickup,
  output logic                  phase3_voltage_pickup,
  output logic                  phase1_current_pickup,
  output logic                  phase2_current_pickup,
  output logic                  phase3_current_pickup,
  output logic                  line_deenergised_flag,
  output logic                  line_energised_flag,
  output logic                  supervision_armed,
  output logic                  vt_circuit_fault_flag
);
  typedef enum logic [3:0] {
    VTSD_IDLE    = 4'b0001,
    VTSD_ARMING  = 4'b0010,
    VTSD_WATCH   = 4'b0100,
    VTSD_FAULT   = 4'b1000
  } vtsd_state_e;

  localparam int unsigned CW = vtsd_pkg::MS_W;

  vtsd_tick_if tick_bus ();

  vtsd_ms_tick #(
    .DIV    (TICK_DIV)
  ) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick_o  (tick_bus)
  );

  // thresholds clamped into their settable range
  logic [7:0] vthr;
  logic [7:0] ithr;
  always_comb begin
    vthr = voltage_threshold_pct; // RQ19
    if (vthr < vtsd_pkg::VTHR_MIN) vthr = vtsd_pkg::VTHR_MIN;
    if (vthr > vtsd_pkg::THR_MAX) vthr = vtsd_pkg::THR_MAX;
    ithr = current_threshold_pct; // RQ19
    if (ithr < vtsd_pkg::ITHR_MIN) ithr = vtsd_pkg::ITHR_MIN;
    if (ithr > vtsd_pkg::THR_MAX) ithr = vtsd_pkg::THR_MAX;
  end

  // detector operable only when on and not inhibited
  logic operable;
  assign operable = detector_enable && !line_state_inhibit; // RQ11 RQ17 RQ18

  // per-phase comparisons, strict above for pickup
  logic [2:0] v_above;
  logic [2:0] i_above;
  logic [2:0] v_below;
  logic [2:0] i_below;
  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign v_above[p] = phase_voltage_mag[p] > MAG_W'(vthr); // RQ3
    assign i_above[p] = phase_current_mag[p] > MAG_W'(ithr); // RQ4
    assign v_below[p] = phase_voltage_mag[p] < MAG_W'(vthr);
    assign i_below[p] = phase_current_mag[p] < MAG_W'(ithr);
  end

  logic dead_now;
  logic live_now;
  assign dead_now = operable && (&v_below) && (&i_below); // RQ1
  assign live_now = operable && (&v_above);               // RQ2

  // mode condition; reserved mode code 3 never fails
  logic cond;
  always_comb begin
    case (supervision_mode) // RQ22
      vtsd_pkg::MODE_RESIDUAL: cond = (residual_voltage_mag > residual_voltage_thr)
                                   && (residual_current_mag < residual_current_thr); // RQ5
      vtsd_pkg::MODE_NEGSEQ:   cond = (negseq_voltage_mag > negseq_voltage_thr)
                                   && (negseq_current_mag < negseq_current_thr); // RQ6
      vtsd_pkg::MODE_SPECIAL:  cond = (residual_voltage_mag > residual_voltage_thr)
                                   && (residual_current_mag < residual_current_thr)
                                   && (negseq_current_mag < negseq_current_thr); // RQ7
      default:                 cond = 1'b0;
    endcase
  end

  // status registers
  logic [2:0] vpick_q;
  logic [2:0] vpick_d;
  logic [2:0] ipick_q;
  logic [2:0] ipick_d;
  logic       dead_q;
  logic       dead_d;
  logic       live_q;
  logic       live_d;

  // pickups and line state, all forced low when not operable
  always_comb begin
    vpick_d = operable ? v_above : 3'b000; // RQ17 RQ18
    ipick_d = operable ? i_above : 3'b000; // RQ17 RQ18
    dead_d  = dead_now;
    live_d  = live_now;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      vpick_q <= 3'b000;
      ipick_q <= 3'b000;
      dead_q  <= 1'b0;
      live_q  <= 1'b0;
    end else begin
      vpick_q <= vpick_d;
      ipick_q <= ipick_d;
      dead_q  <= dead_d;
      live_q  <= live_d;
    end
  end

  // supervisor timers; each counter saturates at its target, except rst_q while the fault is latched
  vtsd_state_e st_q;
  vtsd_state_e st_d;
  logic [CW-1:0] arm_q;
  logic [CW-1:0] arm_d;
  logic [CW-1:0] cond_q;
  logic [CW-1:0] cond_d;
  logic [CW-1:0] rst_q;
  logic [CW-1:0] rst_d;
  logic [CW-1:0] hold_q;
  logic [CW-1:0] hold_d;
  logic          latch_q;
  logic          latch_d;
  logic          dead_rise;
  logic          tick;

  assign tick      = tick_bus.tick;
  assign dead_rise = dead_d && !dead_q;

  // state and counter next values
  always_comb begin
    st_d    = st_q;
    arm_d   = arm_q;
    cond_d  = cond_q;
    rst_d   = rst_q;
    hold_d  = hold_q;
    latch_d = latch_q;
    // live line continuity counter
    if (!live_now) arm_d = '0; // RQ20
    else if (tick && arm_q < CW'(ARM_MS)) arm_d = arm_q + CW'(1); // RQ8
    // condition continuity counter
    if (!cond) cond_d = '0; // RQ20
    else if (tick && cond_q < CW'(FAIL_MS)) cond_d = cond_q + CW'(1);
    if (!operable) begin
      // no fault may stand while the detector is not operable
      st_d    = VTSD_IDLE; // RQ11
      latch_d = 1'b0;
      hold_d  = '0;
      rst_d   = '0;
    end else begin
      case (st_q)
        VTSD_IDLE: begin
          if (live_now) st_d = VTSD_ARMING;
        end
        VTSD_ARMING: begin
          if (!live_now) st_d = VTSD_IDLE;
          else if (arm_q >= CW'(ARM_MS)) st_d = VTSD_WATCH; // RQ8
        end
        VTSD_WATCH: begin
          if (dead_now) st_d = VTSD_IDLE; // RQ9
          else if (cond && cond_q >= CW'(FAIL_MS)) begin
            st_d   = VTSD_FAULT; // RQ10
            hold_d = '0;
            rst_d  = '0;
          end
        end
        VTSD_FAULT: begin
          // fault continuity, used for the latching decision
          if (tick && hold_q < CW'(LATCH_MS)) hold_d = hold_q + CW'(1); // RQ20
          if (dead_rise && !latch_q) begin
            if (hold_q >= CW'(LATCH_MS)) latch_d = 1'b1; // RQ13
            else st_d = VTSD_IDLE; // RQ14
          end
          if (latch_q) begin
            // latched: survives dead line; releases via live-line drop-off or when the detector is not operable
            if (live_now && !cond) begin
              if (tick) rst_d = rst_q + CW'(1);
            end else rst_d = '0;
            if (rst_q >= CW'(RESET_MS)) begin
              st_d    = VTSD_WATCH;
              latch_d = 1'b0;
            end
          end else if (!dead_now) begin
            if (!cond && live_now) begin
              if (tick && rst_q < CW'(RESET_MS)) rst_d = rst_q + CW'(1); // RQ12
            end else rst_d = '0; // RQ20
            if (rst_q >= CW'(RESET_MS)) st_d = VTSD_WATCH; // RQ12
          end
        end
        default: st_d = VTSD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q    <= VTSD_IDLE;
      arm_q   <= '0;
      cond_q  <= '0;
      rst_q   <= '0;
      hold_q  <= '0;
      latch_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      arm_q   <= arm_d;
      cond_q  <= cond_d;
      rst_q   <= rst_d;
      hold_q  <= hold_d;
      latch_q <= latch_d;
    end
  end

  // output flops; no event logic here, indication is left to user logic
  logic fault_q;
  logic fault_d;
  logic armed_q;
  logic armed_d;
  always_comb begin
    fault_d = (st_d == VTSD_FAULT); // RQ10 RQ15
    armed_d = (st_d == VTSD_WATCH) || (st_d == VTSD_FAULT);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fault_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      armed_q <= armed_d;
    end
  end

  assign phase1_voltage_pickup = vpick_q[0];
  assign phase2_voltage_pickup = vpick_q[1];
  assign phase3_voltage_pickup = vpick_q[2];
  assign phase1_current_pickup = ipick_q[0];
  assign phase2_current_pickup = ipick_q[1];
  assign phase3_current_pickup = ipick_q[2];
  assign line_deenergised_flag = dead_q; // RQ16
  assign line_energised_flag   = live_q; // RQ16
  assign supervision_armed     = armed_q;
  assign vt_circuit_fault_flag = fault_q;
endmodule : vtsd_top
`default_nettype wire

// ===== vtsd_pkg.sv
// vtsd_pkg: shared constants for the line-state detector and vt circuit supervisor
// assumes a 250 MHz ref_clk and magnitudes scaled as percent of nominal
package vtsd_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / MS_PER_S;     // cycles per ms tick
  localparam int unsigned ARM_MS        = 200;                   // live line before arming
  localparam int unsigned FAIL_MS       = 4;                     // condition qualification
  localparam int unsigned RESET_MS      = 200;                   // drop-off delay on live line
  localparam int unsigned LATCH_MS      = 100;                   // continuity for latching
  localparam int unsigned MAG_W         = 16;
  localparam int unsigned MS_W          = 8;
  localparam logic [7:0]  VTHR_DEFAULT  = 8'h3C;                 // 60 percent
  localparam logic [7:0]  ITHR_DEFAULT  = 8'h0A;                 // 10 percent
  localparam logic [7:0]  VTHR_MIN      = 8'h0A;
  localparam logic [7:0]  ITHR_MIN      = 8'h02;
  localparam logic [7:0]  THR_MAX       = 8'h64;
  localparam logic [1:0]  MODE_RESIDUAL = 2'h0;
  localparam logic [1:0]  MODE_NEGSEQ   = 2'h1;
  localparam logic [1:0]  MODE_SPECIAL  = 2'h2;
endpackage : vtsd_pkg

// ===== vtsd_tick_if.sv
// vtsd_tick_if: millisecond tick carried from the tick generator to the top
// assumes both ends sit on ref_clk
`timescale 1ns/1ns
`default_nettype none
interface vtsd_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : vtsd_tick_if
`default_nettype wire

// ===== vtsd_ms_tick.sv
// vtsd_ms_tick: divides ref_clk down to a one-cycle millisecond tick
// assumes synchronous active-low reset on ref_clk
`timescale 1ns/1ns
`default_nettype none
module vtsd_ms_tick #(
  parameter int unsigned DIV = vtsd_pkg::TICK_CYCLES
) (
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  vtsd_tick_if.src    tick_o
);
  localparam int unsigned CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_q;
  logic          tick_d;

  // free-running divider, tick on wrap
  always_comb begin
    tick_d = (cnt_q == CW'(DIV - 1));
    cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o.tick = tick_q;
endmodule : vtsd_ms_tick
`default_nettype wire

// ===== vtsd_top_asserts.sv
// vtsd_top_asserts: port-level timing and gating checks for vtsd_top
// assumes bind into vtsd_top, all outputs registered on ref_clk
`timescale 1ns/1ns
`default_nettype none
module vtsd_top_checker #(
  parameter int unsigned TICK_DIV = vtsd_pkg::TICK_CYCLES,
  parameter int unsigned ARM_MS   = vtsd_pkg::ARM_MS,
  parameter int unsigned LATCH_MS = vtsd_pkg::LATCH_MS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic detector_enable,
  input wire logic line_state_inhibit,
  input wire logic phase1_voltage_pickup,
  input wire logic phase2_voltage_pickup,
  input wire logic phase3_voltage_pickup,
  input wire logic phase1_current_pickup,
  input wire logic phase2_current_pickup,
  input wire logic phase3_current_pickup,
  input wire logic line_deenergised_flag,
  input wire logic line_energised_flag,
  input wire logic supervision_armed,
  input wire logic vt_circuit_fault_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int unsigned live_q, live_d, fault_q, fault_d;
  logic        vall, vany, iany, dead, fault;
  assign vall = phase1_voltage_pickup & phase2_voltage_pickup & phase3_voltage_pickup;
  assign vany = phase1_voltage_pickup | phase2_voltage_pickup | phase3_voltage_pickup;
  assign iany = phase1_current_pickup | phase2_current_pickup | phase3_current_pickup;
  assign dead = line_deenergised_flag;
  assign fault = vt_circuit_fault_flag;
  // run lengths in cycles; ms figures allow one tick of slack
  always_comb begin
    live_d = line_energised_flag ? live_q + 1 : 0;
    fault_d = fault ? fault_q + 1 : 0;
  end
  always_ff @(posedge ref_clk) begin
    live_q <= resetn ? live_d : 0;
    fault_q <= resetn ? fault_d : 0;
  end
  dead_quiet_a: assert property (dead |-> !(vany || iany))
    else $error("dead line while a pickup is set");
  live_all_a: assert property (line_energised_flag == vall)
    else $error("live line differs from voltage pickups");
  off_quiet_a: assert property ((!detector_enable || line_state_inhibit) |=>
    !(vany || iany || dead || line_energised_flag || supervision_armed || fault))
    else $error("output active while not operable");
  arm_hold_a: assert property ($rose(supervision_armed) |->
    live_q >= (ARM_MS - 1) * TICK_DIV) else $error("armed too early");
  disarm_dead_a: assert property ((dead && !fault) |=> !supervision_armed)
    else $error("armed during dead line");
  fault_armed_a: assert property ($rose(fault) |-> $past(supervision_armed))
    else $error("fault without arming");
  fault_gate_a: assert property (fault |-> $past(detector_enable) &&
    !$past(line_state_inhibit)) else $error("fault while not operable");
  short_drop_a: assert property ($rose(dead) && fault_q > 0 &&
    fault_q < (LATCH_MS - 1) * TICK_DIV |-> ##[0:2] !fault) else $error("short fault kept");
  latch_keep_a: assert property ($rose(dead) &&
    fault_q > (LATCH_MS + 1) * TICK_DIV |-> fault[*8]) else $error("long fault not latched");
  cover property ($rose(supervision_armed));
  cover property ($rose(fault));
  cover property ($rose(dead) && fault);
endmodule : vtsd_top_checker
bind vtsd_top vtsd_top_checker #(.TICK_DIV(TICK_DIV), .ARM_MS(ARM_MS), .LATCH_MS(LATCH_MS)) u_chk (
  .ref_clk, .resetn, .detector_enable, .line_state_inhibit, .phase1_voltage_pickup,
  .phase2_voltage_pickup, .phase3_voltage_pickup, .phase1_current_pickup,
  .phase2_current_pickup, .phase3_current_pickup, .line_deenergised_flag,
  .line_energised_flag, .supervision_armed, .vt_circuit_fault_flag);
`default_nettype wire

// ===== vtsd_meas_model.sv
// vtsd_meas_model: stand-in for the magnitude preprocessing stage
// assumes ref_clk; line_cmd 0 dead, 1 live, 2 phase2 low, 3 phase1 current only
`timescale 1ns/1ns
`default_nettype none
module vtsd_meas_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] line_cmd,
  input  wire logic [3:0] seq_cmd,
  output logic [15:0]     v_mag [3],
  output logic [15:0]     i_mag [3],
  output logic [15:0]     seq_mag [4],
  output logic [15:0]     seq_thr
);
  // refreshed every cycle, far faster than one ms tick needs
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 3; k++) begin
      v_mag[k] <= (line_cmd[0] ^ line_cmd[1]) ?
                  ((line_cmd == 2'h2 && k == 1) ? 16'h0028 : 16'h0050) : 16'h0005;
      i_mag[k] <= (line_cmd == 2'h0 || (line_cmd == 2'h3 && k != 0)) ? 16'h0001 : 16'h0014;
    end
    for (int k = 0; k < 4; k++) begin
      seq_mag[k] <= seq_cmd[k] ? 16'h0040 : 16'h0004; // order: rv ri nv ni from bit 3
    end
    seq_thr <= 16'h0020;
  end
endmodule : vtsd_meas_model
`default_nettype wire

// ===== test_vt_supervision_dead_line_logic.sv
// test_vt_supervision_dead_line_logic: table and sequence checks of vtsd_top
// assumes shortened tick (10 cycles per ms) and timer parameters below
`timescale 1ns/1ns
`default_nettype none
module test_vt_supervision_dead_line_logic;
  localparam int TD = 10;
  localparam int ARM = 20;
  localparam int LAT = 10;
  // rows: thresholds, line_cmd, then {voltage pickups, current pickups, dead, live}
  // third row sits below both settable minimums, so only the clamp keeps it dead
  localparam logic [25:0] rows [7] = '{{8'h1E, 8'h0A, 10'h2FD}, {8'h3C, 8'h20, 10'h1E1},
    {8'h02, 8'h00, 10'h002}, {8'h3C, 8'h0A, 10'h1FD}, {8'h3C, 8'h0A, 10'h002},
    {8'h3C, 8'h0A, 10'h2BC}, {8'h3C, 8'h0A, 10'h304}};
  // modes: mode, failing seq_cmd, near-miss seq_cmd
  localparam logic [9:0] modes [3] = '{10'h08C, 10'h123, 10'h289};
  logic        ref_clk, resetn, en, inh, dead, live, armed, fault;
  logic [1:0]  cmd, mode;
  logic [3:0]  seq;
  logic [2:0]  vp, ip;
  logic [7:0]  vthr_set, ithr_set;
  logic [15:0] vm [3], im [3], sm [4], thr;
  int          mismatches, tests_run;
  vtsd_meas_model u_meas (.ref_clk, .line_cmd(cmd), .seq_cmd(seq), .v_mag(vm), .i_mag(im),
    .seq_mag(sm), .seq_thr(thr));
  vtsd_top #(.TICK_DIV(TD), .ARM_MS(ARM), .FAIL_MS(4), .RESET_MS(20), .LATCH_MS(LAT)) dut (
    .ref_clk, .resetn, .detector_enable(en), .line_state_inhibit(inh),
    .voltage_threshold_pct(vthr_set), .current_threshold_pct(ithr_set),
    .phase_voltage_mag(vm), .phase_current_mag(im), .supervision_mode(mode),
    .residual_voltage_mag(sm[3]), .residual_current_mag(sm[2]),
    .negseq_voltage_mag(sm[1]), .negseq_current_mag(sm[0]),
    .residual_voltage_thr(thr), .residual_current_thr(thr),
    .negseq_voltage_thr(thr), .negseq_current_thr(thr),
    .phase1_voltage_pickup(vp[0]), .phase2_voltage_pickup(vp[1]), .phase3_voltage_pickup(vp[2]),
    .phase1_current_pickup(ip[0]), .phase2_current_pickup(ip[1]), .phase3_current_pickup(ip[2]),
    .line_deenergised_flag(dead), .line_energised_flag(live),
    .supervision_armed(armed), .vt_circuit_fault_flag(fault));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step
  // outputs read at the edge are the settled pre-edge values
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bounded wait on armed (sel 0) or fault (sel 1); a miss ends the run
  task automatic await(input logic sel, input logic want, input int ms);
    int n = 0;
    while (((sel ? fault : armed) !== want) && n < ms * TD) begin
      step(1);
      n++;
    end
    check({7'h00, sel ? fault : armed}, {7'h00, want});
    if (n >= ms * TD) print_verdict();
  endtask : await
  initial begin
    mismatches = 0;
    tests_run = 0;
    resetn = 1'b0;
    en = 1'b0;
    inh = 1'b0;
    cmd = 2'h1;
    seq = 4'h0;
    mode = 2'h0;
    vthr_set = 8'h3C;
    ithr_set = 8'h0A;
    step(20);
    resetn <= 1'b1;
    step(4);
    check({vp, ip, dead, live}, 8'h00);
    en <= 1'b1;
    foreach (rows[r]) begin
      vthr_set <= rows[r][25:18];
      ithr_set <= rows[r][17:10];
      cmd <= rows[r][9:8];
      step(3);
      check({vp, ip, dead, live}, rows[r][7:0]);
    end
    cmd <= 2'h1;
    inh <= 1'b1;
    step(3);
    check({vp, ip, dead, live}, 8'h00);
    inh <= 1'b0;
    step((ARM - 2) * TD);
    check({7'h00, armed}, 8'h00);
    await(1'b0, 1'b1, 4);
    // near miss must stay quiet, then the real condition must not fire early
    foreach (modes[m]) begin
      mode <= modes[m][9:8];
      seq <= modes[m][3:0];
      step(8 * TD);
      check({7'h00, fault}, 8'h00);
      seq <= modes[m][7:4];
      step(3 * TD);
      check({7'h00, fault}, 8'h00);
      await(1'b1, 1'b1, 4);
      seq <= 4'h0;
      step(18 * TD);
      check({7'h00, fault}, 8'h01);
      await(1'b1, 1'b0, 4);
    end
    // reserved mode code must stay quiet with every voltage high and currents low
    mode <= 2'h3;
    seq <= 4'hA;
    step(8 * TD);
    check({7'h00, fault}, 8'h00);
    // a broken-up condition restarts its qualification, two short bursts never fire
    mode <= 2'h2;
    seq <= 4'h8;
    step(3 * TD);
    seq <= 4'h0;
    step(TD);
    seq <= 4'h8;
    step(3 * TD);
    check({7'h00, fault}, 8'h00);
    await(1'b1, 1'b1, 6);
    step(2 * TD);
    cmd <= 2'h0;
    step(5);
    check({6'h00, armed, fault}, 8'h00);
    cmd <= 2'h1;
    await(1'b0, 1'b1, ARM + 3);
    await(1'b1, 1'b1, 6);
    step((LAT + 2) * TD);
    cmd <= 2'h0;
    step(5 * TD);
    check({7'h00, fault}, 8'h01);
    cmd <= 2'h1;
    step(5 * TD);
    check({7'h00, fault}, 8'h01);
    en <= 1'b0;
    step(3);
    check({vp, ip, dead, live}, 8'h00);
    check({6'h00, armed, fault}, 8'h00);
    print_verdict();
  end
endmodule : test_vt_supervision_dead_line_logic
`default_nettype wire
